/* iopm_board.sv */
`timescale 1ns/100ps
module iopm_board import iopm_pkg::*; (
  // Clock.
  input wire logic clk,
  // Device side of the pins.
  input wire iopm_pin_s dev,
  // Board drivers.
  input wire logic [7:0] ext_v,
  input wire logic [7:0] ext_en,
  // Resolved pin level.
  output logic [7:0] pin
);
  logic [7:0] float_pat = 8'h5A;
  // A floating pin without pull-up wanders every cycle.
  always @(posedge clk) begin
    float_pat <= ~float_pat;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin[i] = dev.oe[i] ? dev.o[i] : ext_en[i] ? ext_v[i] :
               dev.pu[i] ? 1'b1 : float_pat[i];
    end
  end
endmodule

/* iopm_pkg.sv */
package iopm_pkg;
  localparam int IOPM_PORT_W = 8;
  localparam logic [7:0] IOPM_CFG_RST = 8'h00;
  localparam logic [7:0] IOPM_DATA_RST = 8'h00;
  localparam logic [7:0] IOPM_PORTD_RST = 8'hFF;
  localparam int IOPM_G_HALT_BIT = 7;
  localparam int IOPM_G_IDLE_BIT = 6;
  localparam int IOPM_G_ALTSK_BIT = 6;
  localparam int IOPM_G_CLOCK_DELAY_SELECT_BIT = 7;
  localparam logic [7:0] IOPM_G_RDMASK = 8'h3F;
  // Register selects for the internal data-memory port.
  localparam logic [4:0] IOPM_R_GDATA = 5'h00;
  localparam logic [4:0] IOPM_R_GCFG = 5'h01;
  localparam logic [4:0] IOPM_R_GIN = 5'h02;
  localparam logic [4:0] IOPM_R_LDATA = 5'h03;
  localparam logic [4:0] IOPM_R_LCFG = 5'h04;
  localparam logic [4:0] IOPM_R_LIN = 5'h05;
  localparam logic [4:0] IOPM_R_MDATA = 5'h06;
  localparam logic [4:0] IOPM_R_MCFG = 5'h07;
  localparam logic [4:0] IOPM_R_MIN = 5'h08;
  localparam logic [4:0] IOPM_R_NDATA = 5'h09;
  localparam logic [4:0] IOPM_R_NCFG = 5'h0A;
  localparam logic [4:0] IOPM_R_NIN = 5'h0B;
  localparam logic [4:0] IOPM_R_NALT = 5'h0C;
  localparam logic [4:0] IOPM_R_DDATA = 5'h0D;
  localparam logic [4:0] IOPM_R_IIN = 5'h0E;
  localparam logic [4:0] IOPM_R_CANCTL = 5'h0F;
  localparam int IOPM_CAN_CAN_TRANSMIT_ENABLE_ZERO_BIT = 0;
  localparam int IOPM_CAN_CAN_TRANSMIT_ENABLE_ONE_BIT = 1;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pu;
  } iopm_pin_s;
endpackage

/* iopm_tb.sv */
`timescale 1ns/100ps
module tb import iopm_pkg::*;;
  logic MCLK = 1'b0, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
  logic [4:0] REG_ADDR = 5'h00;
  logic [7:0] REG_WDATA = 8'h00, PI_IN = 8'h00, WAKE_ENABLE = 8'h00;
  logic [7:0] SPI_SHIFT = 8'h00, REG_RDATA, PD_OUT, ANALOG_CHANNEL;
  logic [7:0] PG_IN, PG_OUT, PG_OE, PG_PU, PL_IN, PL_OUT, PL_OE, PL_PU;
  logic [7:0] PM_IN, PM_OUT, PM_OE, PM_PU, PN_IN, PN_OUT, PN_OE, PN_PU;
  logic [7:0] ev [4] = '{default: 8'h00};
  logic [7:0] ee [4] = '{default: 8'h00};
  logic OSCILLATOR_OUTPUT = 1'b0, SYNC_SERIAL_SEL = 1'b0;
  logic SYNC_SERIAL_CLOCK_O = 1'b0, SYNC_SERIAL_DATA_O = 1'b0;
  logic TIMER_ONE_IO_O = 1'b0, TIMER_ONE_IO_OE = 1'b0;
  logic SUPERVISOR_ERROR_N = 1'b1, ASYNC_SERIAL_TX_EN = 1'b0;
  logic ASYNC_SERIAL_TRANSMIT = 1'b0, ASYNC_SERIAL_CLOCK_OE = 1'b0;
  logic ASYNC_SERIAL_CLOCK_O = 1'b0, SPI_ENABLE = 1'b0, SPI_MASTER = 1'b0;
  logic SPI_SS_O_N = 1'b1, SPI_SCK_O = 1'b0, SPI_MOSI_O = 1'b0;
  logic SPI_MISO_O = 1'b0, TIMER_TWO_SEL_A = 1'b0, TIMER_TWO_SEL_B = 1'b0;
  logic TIMER_TWO_IO_A_O = 1'b0, TIMER_TWO_IO_B_O = 1'b0;
  logic TIMER_TWO_OE_A = 1'b0, TIMER_TWO_OE_B = 1'b0, CAN_WAKE_SEL = 1'b0;
  logic CAN_RX_ACTIVITY = 1'b0, CAN_RECEIVE_IN_ZERO = 1'b1;
  logic CAN_RECEIVE_IN_ONE = 1'b1, CAN_TX_DATA = 1'b0;
  logic HALT_REQ, IDLE_REQ, SK_ALT_PHASE, CLOCK_DELAY_SELECT;
  logic SYNC_SERIAL_DATA_I, SYNC_SERIAL_CLOCK_I, TIMER_ONE_IO_I;
  logic TIMER_ONE_CAPTURE, EXTERNAL_INTERRUPT_INPUT, ASYNC_SERIAL_RECEIVE;
  logic ASYNC_SERIAL_CLOCK_I, SPI_SS_I_N, SPI_SCK_I, SPI_MOSI_I, SPI_MISO_I;
  logic TIMER_TWO_IO_A, TIMER_TWO_IO_B, MULTI_INPUT_WAKEUP, CAN_RX_DATA;
  logic CAN_TRANSMIT_OUT_ZERO, CAN_TRANSMIT_OUT_ONE;
  logic CAN_TRANSMIT_OE_ZERO, CAN_TRANSMIT_OE_ONE;
  int miscompares = 0;
  int checks_done = 0;

  iopm_top DUT (.*);
  iopm_board BG (.clk(MCLK), .dev({PG_OUT, PG_OE, PG_PU}), .ext_v(ev[0]),
    .ext_en(ee[0]), .pin(PG_IN));
  iopm_board BL (.clk(MCLK), .dev({PL_OUT, PL_OE, PL_PU}), .ext_v(ev[1]),
    .ext_en(ee[1]), .pin(PL_IN));
  iopm_board BM (.clk(MCLK), .dev({PM_OUT, PM_OE, PM_PU}), .ext_v(ev[2]),
    .ext_en(ee[2]), .pin(PM_IN));
  iopm_board BN (.clk(MCLK), .dev({PN_OUT, PN_OE, PN_PU}), .ext_v(ev[3]),
    .ext_en(ee[3]), .pin(PN_IN));

  always #5 MCLK = ~MCLK;

  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task step;
    @(posedge MCLK);
    #1;
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    step;
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    step;
    REG_WR = 1'b0;
  endtask
  task rd(input logic [4:0] a, input logic [7:0] e,
    input logic [7:0] m = 8'hFF);
    step;
    REG_RD = 1'b1;
    REG_ADDR = a;
    step;
    chk(REG_RDATA & m, e);
    REG_RD = 1'b0;
  endtask
  task wake(input logic e);
    logic seen;
    seen = 1'b0;
    repeat (6) begin
      @(negedge MCLK);
      if (MULTI_INPUT_WAKEUP === 1'b1) seen = 1'b1;
    end
    step;
    chk({7'h00, seen}, {7'h00, e});
  endtask

  task t_wake;
    ee[1] = 8'hFF;
    ee[2] = 8'hFF;
    repeat (4) step;
    WAKE_ENABLE = 8'hFF;
    wake(1'b0);
    ev[1] = 8'h08;
    wake(1'b1);
    ev[2] = 8'h01;
    wake(1'b1);
    CAN_WAKE_SEL = 1'b1;
    repeat (4) step;
    ev[2] = 8'h81;
    wake(1'b0);
    rd(IOPM_R_MIN, 8'h81);
    CAN_RX_ACTIVITY = 1'b1;
    wake(1'b1);
    WAKE_ENABLE = 8'h00;
    $display("wakeup test done");
  endtask
  task t_lport;
    ee[1] = 8'h00;
    wr(IOPM_R_LCFG, 8'hF0);
    wr(IOPM_R_LDATA, 8'hCC);
    chk(PL_OE, 8'hF0);
    chk(PL_OUT & 8'hF0, 8'hC0);
    chk(PL_PU, 8'h0C);
    rd(IOPM_R_LCFG, 8'hF0);
    rd(IOPM_R_LIN, 8'hCC, 8'hFC);
    ASYNC_SERIAL_TX_EN = 1'b1;
    step;
    chk({PL_OE[2], PL_OUT[2], 5'h00, ASYNC_SERIAL_RECEIVE}, 8'h81);
    ASYNC_SERIAL_TX_EN = 1'b0;
    $display("port L test done");
  endtask
  task t_gport;
    ee[0] = 8'h40;
    ev[0] = 8'h40;
    wr(IOPM_R_GDATA, 8'hFF);
    chk({6'h00, HALT_REQ, IDLE_REQ}, 8'h03);
    rd(IOPM_R_GDATA, 8'h3F);
    chk(PG_PU & 8'h3F, 8'h3F);
    chk({3'h0, SYNC_SERIAL_DATA_I, SYNC_SERIAL_CLOCK_I, TIMER_ONE_IO_I,
      TIMER_ONE_CAPTURE, EXTERNAL_INTERRUPT_INPUT}, 8'h1F);
    wr(IOPM_R_GCFG, 8'hC0);
    chk({6'h00, SK_ALT_PHASE, CLOCK_DELAY_SELECT}, 8'h03);
    OSCILLATOR_OUTPUT = 1'b1;
    SUPERVISOR_ERROR_N = 1'b0;
    step;
    chk({4'h0, PG_OE[7], PG_OUT[7], PG_OE[1], PG_OUT[1]}, 8'h0E);
    SUPERVISOR_ERROR_N = 1'b1;
    wr(IOPM_R_GDATA, 8'h00);
    chk({6'h00, HALT_REQ, IDLE_REQ}, 8'h00);
    $display("port G test done");
  endtask
  task t_mport;
    ee[2] = 8'h01;
    wr(IOPM_R_MCFG, 8'h00);
    wr(IOPM_R_MDATA, 8'hFF);
    SPI_MASTER = 1'b1;
    SPI_ENABLE = 1'b1;
    SPI_SS_O_N = 1'b0;
    SPI_SCK_O = 1'b1;
    repeat (3) step;
    chk(PM_OE & 8'h0F, 8'h0E);
    chk(PM_OUT & 8'h0E, 8'h04);
    chk({4'h0, SPI_SS_I_N, SPI_SCK_I, SPI_MOSI_I, SPI_MISO_I}, 8'h05);
    SPI_MASTER = 1'b0;
    TIMER_TWO_SEL_A = 1'b1;
    TIMER_TWO_OE_A = 1'b1;
    step;
    chk(PM_OE & 8'h1F, 8'h11);
    chk(PM_OUT & 8'h11, 8'h00);
    chk({6'h00, TIMER_TWO_IO_B, TIMER_TWO_IO_A}, 8'h02);
    SPI_ENABLE = 1'b0;
    TIMER_TWO_SEL_A = 1'b0;
    wr(IOPM_R_MCFG, 8'h0F);
    chk(PM_OE, 8'h0F);
    chk(PM_OUT & 8'h1F, 8'h1F);
    $display("port M test done");
  endtask
  task t_nport;
    wr(IOPM_R_NCFG, 8'hFF);
    wr(IOPM_R_NALT, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      SPI_SHIFT = i[7:0];
      repeat (2) step;
      chk(PN_OUT, ~(8'h01 << i));
    end
    SPI_SS_O_N = 1'b1;
    repeat (2) step;
    chk(PN_OUT, 8'hFF);
    chk(PN_OE, 8'hFF);
    $display("port N test done");
  endtask
  task t_misc;
    CAN_TX_DATA = 1'b1;
    wr(IOPM_R_CANCTL, 8'h01);
    chk({CAN_TRANSMIT_OE_ONE, CAN_TRANSMIT_OE_ZERO, 6'h00}, 8'h40);
    wr(IOPM_R_CANCTL, 8'h02);
    chk({CAN_TRANSMIT_OE_ONE, CAN_TRANSMIT_OE_ZERO, 6'h00}, 8'h80);
    chk({CAN_TRANSMIT_OUT_ONE, CAN_TRANSMIT_OUT_ZERO, 6'h00}, 8'hC0);
    chk({7'h00, CAN_RX_DATA}, 8'h01);
    wr(IOPM_R_DDATA, 8'h5A);
    chk(PD_OUT, 8'h5A);
    PI_IN = 8'hC3;
    repeat (3) step;
    rd(IOPM_R_IIN, 8'hC3);
    chk(ANALOG_CHANNEL, 8'hC3);
    rd(5'h15, 8'h00);
    $display("CAN and port D test done");
  endtask
  task t_reset;
    RST_N = 1'b0;
    repeat (2) step;
    chk(PD_OUT, IOPM_PORTD_RST);
    rd(IOPM_R_GCFG, IOPM_CFG_RST);
    rd(IOPM_R_LCFG, IOPM_CFG_RST);
    rd(IOPM_R_LDATA, IOPM_DATA_RST);
    chk(PL_OE, 8'h00);
    chk(PG_OE & 8'h7F, 8'h00);
    RST_N = 1'b1;
    $display("reset test done");
  endtask

  task print_verdict;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge MCLK);
    #1 RST_N = 1'b1;
    t_wake;
    t_lport;
    t_gport;
    t_mport;
    t_nport;
    t_misc;
    t_reset;
    print_verdict;
  end
  initial begin
    #20000;
    miscompares++;
    print_verdict;
  end
endmodule

/* iopm_top.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - Config/data pair selects hi-z, pull-up, low, high.
// - Ports G, L, M, N: config, data, and input location.
// - Port G data bits 6,7 read zero.
// - Writing one to G data bit7 halts.
// - Writing one to G data bit6 idles.
// - G config bit6 inverts serial clock; bit7 delay.
// - Port G pins carry serial, timer, interrupt alternates.
// - L and M pins wake; L carries serial.
// - L and M wakeups share one interrupt.
// - Selected M alternate overrides config and data.
// - Alternate wakeup masks pin, input still readable.
// - SPI enabled owns M0-M3 with role direction.
// - CAN wakes via M7; M5,M4 carry timer two.
// - Expander decodes eight exclusive extended selects.
// - Port N alternate drives pin like data bit.
// - Each CAN transmit pin enabled by own bit.
// - Port D output only, high during reset.
// - Port I eight-bit input only, analog.
// - Reset clears L and G registers.
module iopm_top import iopm_pkg::*; #(
  parameter int W = IOPM_PORT_W
) (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RST_N,
  // Internal register port.
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [4:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Port G pins.
  input wire logic [7:0] PG_IN,
  output logic [7:0] PG_OUT,
  output logic [7:0] PG_OE,
  output logic [7:0] PG_PU,
  // Port L pins.
  input wire logic [7:0] PL_IN,
  output logic [7:0] PL_OUT,
  output logic [7:0] PL_OE,
  output logic [7:0] PL_PU,
  // Port M pins.
  input wire logic [7:0] PM_IN,
  output logic [7:0] PM_OUT,
  output logic [7:0] PM_OE,
  output logic [7:0] PM_PU,
  // Port N pins.
  input wire logic [7:0] PN_IN,
  output logic [7:0] PN_OUT,
  output logic [7:0] PN_OE,
  output logic [7:0] PN_PU,
  // Port D and port I pins.
  output logic [7:0] PD_OUT,
  input wire logic [7:0] PI_IN,
  output logic [7:0] ANALOG_CHANNEL,
  // Power and clock control.
  output logic HALT_REQ,
  output logic IDLE_REQ,
  output logic SK_ALT_PHASE,
  output logic CLOCK_DELAY_SELECT,
  // Port G alternates.
  input wire logic OSCILLATOR_OUTPUT,
  input wire logic SYNC_SERIAL_SEL,
  input wire logic SYNC_SERIAL_CLOCK_O,
  input wire logic SYNC_SERIAL_DATA_O,
  output logic SYNC_SERIAL_DATA_I,
  output logic SYNC_SERIAL_CLOCK_I,
  input wire logic TIMER_ONE_IO_O,
  input wire logic TIMER_ONE_IO_OE,
  output logic TIMER_ONE_IO_I,
  output logic TIMER_ONE_CAPTURE,
  input wire logic SUPERVISOR_ERROR_N,
  output logic EXTERNAL_INTERRUPT_INPUT,
  // Port L alternates.
  input wire logic ASYNC_SERIAL_TX_EN,
  input wire logic ASYNC_SERIAL_TRANSMIT,
  output logic ASYNC_SERIAL_RECEIVE,
  input wire logic ASYNC_SERIAL_CLOCK_OE,
  input wire logic ASYNC_SERIAL_CLOCK_O,
  output logic ASYNC_SERIAL_CLOCK_I,
  // Port M alternates.
  input wire logic SPI_ENABLE,
  input wire logic SPI_MASTER,
  input wire logic SPI_SS_O_N,
  input wire logic SPI_SCK_O,
  input wire logic SPI_MOSI_O,
  input wire logic SPI_MISO_O,
  output logic SPI_SS_I_N,
  output logic SPI_SCK_I,
  output logic SPI_MOSI_I,
  output logic SPI_MISO_I,
  input wire logic TIMER_TWO_SEL_A,
  input wire logic TIMER_TWO_SEL_B,
  input wire logic TIMER_TWO_IO_A_O,
  input wire logic TIMER_TWO_IO_B_O,
  input wire logic TIMER_TWO_OE_A,
  input wire logic TIMER_TWO_OE_B,
  output logic TIMER_TWO_IO_A,
  output logic TIMER_TWO_IO_B,
  input wire logic CAN_WAKE_SEL,
  input wire logic CAN_RX_ACTIVITY,
  input wire logic [7:0] WAKE_ENABLE,
  output logic MULTI_INPUT_WAKEUP,
  // Expander and CAN pins.
  input wire logic [7:0] SPI_SHIFT,
  input wire logic CAN_RECEIVE_IN_ZERO,
  input wire logic CAN_RECEIVE_IN_ONE,
  input wire logic CAN_TX_DATA,
  output logic CAN_RX_DATA,
  output logic CAN_TRANSMIT_OUT_ZERO,
  output logic CAN_TRANSMIT_OUT_ONE,
  output logic CAN_TRANSMIT_OE_ZERO,
  output logic CAN_TRANSMIT_OE_ONE
);
  logic [7:0] g_data, g_cfg, l_data, l_cfg, m_data, m_cfg;
  logic [7:0] n_data, n_cfg, port_n_alternate_enable, d_data;
  logic [1:0] can_ctl;
  logic [7:0] ess_n, n_eff_data, l_last, m_last, m_wake_src;
  iopm_pin_s pg, pl, pm, pn;

  function automatic iopm_pin_s setup(input logic [7:0] cfg,
                                      input logic [7:0] dat);
    iopm_pin_s r;
    r.o = dat;
    r.oe = cfg;
    r.pu = ~cfg & dat;
    return r;
  endfunction

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      g_data <= IOPM_DATA_RST;
      g_cfg <= IOPM_CFG_RST;
      l_data <= IOPM_DATA_RST;
      l_cfg <= IOPM_CFG_RST;
      m_data <= IOPM_DATA_RST;
      m_cfg <= IOPM_CFG_RST;
      n_data <= IOPM_DATA_RST;
      n_cfg <= IOPM_CFG_RST;
      port_n_alternate_enable <= IOPM_DATA_RST;
      can_ctl <= 2'h0;
    end else if (REG_WR) begin
      unique case (REG_ADDR)
        IOPM_R_GDATA: g_data <= REG_WDATA;
        IOPM_R_GCFG: g_cfg <= REG_WDATA;
        IOPM_R_LDATA: l_data <= REG_WDATA;
        IOPM_R_LCFG: l_cfg <= REG_WDATA;
        IOPM_R_MDATA: m_data <= REG_WDATA;
        IOPM_R_MCFG: m_cfg <= REG_WDATA;
        IOPM_R_NDATA: n_data <= REG_WDATA;
        IOPM_R_NCFG: n_cfg <= REG_WDATA;
        IOPM_R_NALT: port_n_alternate_enable <= REG_WDATA;
        IOPM_R_CANCTL: can_ctl <= REG_WDATA[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      d_data <= IOPM_PORTD_RST;
    end else if (REG_WR && REG_ADDR == IOPM_R_DDATA) begin
      d_data <= REG_WDATA;
    end
  end
  assign PD_OUT = d_data;

  assign HALT_REQ = g_data[IOPM_G_HALT_BIT];
  assign IDLE_REQ = g_data[IOPM_G_IDLE_BIT];
  assign SK_ALT_PHASE = g_cfg[IOPM_G_ALTSK_BIT];
  assign CLOCK_DELAY_SELECT = g_cfg[IOPM_G_CLOCK_DELAY_SELECT_BIT];

  always_comb begin
    unique case (REG_ADDR)
      IOPM_R_GDATA: REG_RDATA = g_data & IOPM_G_RDMASK;
      IOPM_R_GCFG: REG_RDATA = g_cfg;
      IOPM_R_GIN: REG_RDATA = PG_IN;
      IOPM_R_LDATA: REG_RDATA = l_data;
      IOPM_R_LCFG: REG_RDATA = l_cfg;
      IOPM_R_LIN: REG_RDATA = PL_IN;
      IOPM_R_MDATA: REG_RDATA = m_data;
      IOPM_R_MCFG: REG_RDATA = m_cfg;
      IOPM_R_MIN: REG_RDATA = PM_IN;
      IOPM_R_NDATA: REG_RDATA = n_data;
      IOPM_R_NCFG: REG_RDATA = n_cfg;
      IOPM_R_NIN: REG_RDATA = PN_IN;
      IOPM_R_NALT: REG_RDATA = port_n_alternate_enable;
      IOPM_R_DDATA: REG_RDATA = d_data;
      IOPM_R_IIN: REG_RDATA = PI_IN;
      IOPM_R_CANCTL: REG_RDATA = {6'h00, can_ctl};
      default: REG_RDATA = 8'h00;
    endcase
  end
  assign ANALOG_CHANNEL = PI_IN;

  always_comb begin
    pg = setup(g_cfg, g_data);
    pg.pu[7:6] = 2'h0;
    pg.oe[7:6] = 2'h2;
    pg.o[7:6] = {OSCILLATOR_OUTPUT, 1'b0};
    if (SYNC_SERIAL_SEL) begin
      pg.o[5] = SYNC_SERIAL_CLOCK_O;
      pg.o[4] = SYNC_SERIAL_DATA_O;
    end
    if (TIMER_ONE_IO_OE) begin
      pg.o[3] = TIMER_ONE_IO_O;
      pg.oe[3] = 1'b1;
    end
    if (!SUPERVISOR_ERROR_N) begin
      pg.o[1] = 1'b0;
      pg.oe[1] = 1'b1;
    end
  end
  assign SYNC_SERIAL_DATA_I = PG_IN[6];
  assign SYNC_SERIAL_CLOCK_I = PG_IN[5];
  assign TIMER_ONE_IO_I = PG_IN[3];
  assign TIMER_ONE_CAPTURE = PG_IN[2];
  assign EXTERNAL_INTERRUPT_INPUT = PG_IN[0];

  always_comb begin
    pl = setup(l_cfg, l_data);
    if (ASYNC_SERIAL_TX_EN) begin
      pl.o[2] = ASYNC_SERIAL_TRANSMIT;
      pl.oe[2] = 1'b1;
    end
    if (ASYNC_SERIAL_CLOCK_OE) begin
      pl.o[1] = ASYNC_SERIAL_CLOCK_O;
      pl.oe[1] = 1'b1;
    end
  end
  assign ASYNC_SERIAL_RECEIVE = PL_IN[3];
  assign ASYNC_SERIAL_CLOCK_I = PL_IN[1];

  always_comb begin
    pm = setup(m_cfg, m_data);
    if (SPI_ENABLE) begin
      pm.pu[3:0] = 4'h0;
      pm.oe[3:1] = {3{SPI_MASTER}};
      pm.oe[0] = !SPI_MASTER;
      pm.o[3] = SPI_SS_O_N;
      pm.o[2] = SPI_SCK_O;
      pm.o[1] = SPI_MOSI_O;
      pm.o[0] = SPI_MISO_O;
    end
    if (TIMER_TWO_SEL_A) begin
      pm.o[4] = TIMER_TWO_IO_A_O;
      pm.oe[4] = TIMER_TWO_OE_A;
      pm.pu[4] = 1'b0;
    end
    if (TIMER_TWO_SEL_B) begin
      pm.o[5] = TIMER_TWO_IO_B_O;
      pm.oe[5] = TIMER_TWO_OE_B;
      pm.pu[5] = 1'b0;
    end
  end
  assign SPI_SS_I_N = PM_IN[3];
  assign SPI_SCK_I = PM_IN[2];
  assign SPI_MOSI_I = PM_IN[1];
  assign SPI_MISO_I = PM_IN[0];
  assign TIMER_TWO_IO_A = PM_IN[4];
  assign TIMER_TWO_IO_B = PM_IN[5];

  genvar k;
  generate
    for (k = 0; k < W; k++) begin : g_ess
      assign ess_n[k] = !(!SPI_SS_O_N && SPI_SHIFT[2:0] == 3'(k));
    end
  endgenerate

  assign n_eff_data = (n_data & ~port_n_alternate_enable)
                    | (ess_n & port_n_alternate_enable);
  assign pn = setup(n_cfg, n_eff_data);

  always_comb begin
    m_wake_src = PM_IN;
    m_wake_src[7] = CAN_WAKE_SEL ? CAN_RX_ACTIVITY : PM_IN[7];
    if (SPI_ENABLE) begin
      m_wake_src[3:0] = m_last[3:0];
    end
    if (TIMER_TWO_SEL_A) begin
      m_wake_src[4] = m_last[4];
    end
    if (TIMER_TWO_SEL_B) begin
      m_wake_src[5] = m_last[5];
    end
  end
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      l_last <= 8'h00;
      m_last <= 8'h00;
    end else begin
      l_last <= PL_IN;
      m_last <= m_wake_src;
    end
  end
  assign MULTI_INPUT_WAKEUP = |(((l_last ^ PL_IN) | (m_last ^ m_wake_src))
                                & WAKE_ENABLE);

  assign CAN_TRANSMIT_OUT_ZERO = CAN_TX_DATA;
  assign CAN_TRANSMIT_OUT_ONE = CAN_TX_DATA;
  assign CAN_TRANSMIT_OE_ZERO = can_ctl[IOPM_CAN_CAN_TRANSMIT_ENABLE_ZERO_BIT];
  assign CAN_TRANSMIT_OE_ONE = can_ctl[IOPM_CAN_CAN_TRANSMIT_ENABLE_ONE_BIT];
  assign CAN_RX_DATA = CAN_RECEIVE_IN_ZERO & CAN_RECEIVE_IN_ONE;

  assign PG_OUT = pg.o;
  assign PG_OE = pg.oe;
  assign PG_PU = pg.pu;
  assign PL_OUT = pl.o;
  assign PL_OE = pl.oe;
  assign PL_PU = pl.pu;
  assign PM_OUT = pm.o;
  assign PM_OE = pm.oe;
  assign PM_PU = pm.pu;
  assign PN_OUT = pn.o;
  assign PN_OE = pn.oe;
  assign PN_PU = pn.pu;

  AST_RESET_LG: assert property (@(posedge MCLK)
    !RST_N |=> (PL_OE == 8'h00 && PL_PU == 8'h00 && PG_OE[5:0] == 6'h00))
    else $error("ports L or G not released after reset");
  AST_PORTD_HIGH: assert property (@(posedge MCLK)
    !RST_N |=> PD_OUT == 8'hFF)
    else $error("port D not preset high");
  AST_G_READ_ZERO: assert property (@(posedge MCLK) disable iff (!RST_N)
    REG_ADDR == IOPM_R_GDATA |-> REG_RDATA[7:6] == 2'h0)
    else $error("port G bits 6,7 read nonzero");
  AST_HALT: assert property (@(posedge MCLK) disable iff (!RST_N)
    REG_WR && REG_ADDR == IOPM_R_GDATA && REG_WDATA[7] |=> HALT_REQ)
    else $error("halt not requested");
  AST_IDLE: assert property (@(posedge MCLK) disable iff (!RST_N)
    REG_WR && REG_ADDR == IOPM_R_GDATA && REG_WDATA[6] |=> IDLE_REQ)
    else $error("idle not requested");
  AST_PULLUP: assert property (@(posedge MCLK) disable iff (!RST_N)
    !SPI_ENABLE && !TIMER_TWO_SEL_A && !TIMER_TWO_SEL_B
    |-> PM_PU == (~m_cfg & m_data) && PM_OE == m_cfg)
    else $error("port M setup mismatch");
  AST_SPI_DIR: assert property (@(posedge MCLK) disable iff (!RST_N)
    SPI_ENABLE |-> PM_OE[2] == SPI_MASTER && PM_OE[0] == !SPI_MASTER)
    else $error("SPI direction wrong");
  AST_ESS_ONEHOT: assert property (@(posedge MCLK) disable iff (!RST_N)
    $countones(~ess_n) == (SPI_SS_O_N ? 0 : 1))
    else $error("extended selects not exclusive");
  AST_CAN_TXEN: assert property (@(posedge MCLK) disable iff (!RST_N)
    REG_WR && REG_ADDR == IOPM_R_CANCTL
    |=> CAN_TRANSMIT_OE_ZERO == $past(REG_WDATA[0]))
    else $error("CAN transmit enable mismatch");
  AST_N_ROUTE: assert property (@(posedge MCLK) disable iff (!RST_N)
    port_n_alternate_enable[0] |-> PN_OUT[0] == ess_n[0])
    else $error("port N alternate not routed");
endmodule
